/* rtl/perf_event_counter_bank.sv */
// event counter bank: counter/selector pairs, apb registers, counter read port
// ---------------------------------------------------------------------------
// Behaviour
// (RL1) four core pairs always present
// (RL2) core extension adds two pairs, six total
// (RL3) interconnect and cache groups, four pairs each
// (RL4) counter counts only its own selector's event
// (RL5) extended core pairs 0-3 alias legacy
// (RL6) counter width parameter, at most 64 bits
// (RL7) privileged read and write load counters
// (RL8) read by index: high word, low word
// (RL9) user read needs enable bit, else fault
// (RL10) event mode increments per occurrence
// (RL11) duration mode adds one per cycle
// (RL12) overflow can signal an interrupt
// (RL13) software preloads negative count for interrupt
// (RL14) counter read is not serialising
// (RL15) read instruction reaches all three groups
// (RL16) selector enable gates counting
// (RL17) selector interrupt enable gates interrupt
// (RL18) all-ones wraps to zero, marks overflow only when selector interrupt enable is set
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
module perf_event_counter_bank
    import pmc_pkg::*;
#(
    parameter int CTR_W = 48
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // hardware event and duration sources, one per pair
    input wire logic [MAX_PAIRS-1:0] eventPulse,
    input wire logic [MAX_PAIRS-1:0] durationActive,
    // counter read instruction
    input wire logic readReq,
    input wire logic [31:0] readIndex,
    input wire logic readUser,
    output logic readDone,
    output logic readFault,
    output logic [31:0] readHigh,
    output logic [31:0] readLow,
    // overflow interrupt
    output logic overflowIrq
);
    initial begin
        if (CTR_W < 33 || CTR_W > CTR_MAX_W) begin
            $error("CTR_W must lie in 33..64");
        end
    end

    // -----------------------------------------------------------------------
    // event inputs
    // -----------------------------------------------------------------------
    logic [MAX_PAIRS-1:0] evSync;
    logic [MAX_PAIRS-1:0] durSync;
    logic [MAX_PAIRS-1:0] evSel;
    logic [MAX_PAIRS-1:0] present;

    pmc_sync2 #(.W(MAX_PAIRS)) u_sync_ev (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(eventPulse),
        .dout(evSync)
    );

    pmc_sync2 #(.W(MAX_PAIRS)) u_sync_dur (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(durationActive),
        .dout(durSync)
    );

    // -----------------------------------------------------------------------
    // control and status
    // -----------------------------------------------------------------------
    logic [3:0] ctrl_reg;
    logic [MAX_PAIRS-1:0] ovf_reg;
    logic [MAX_PAIRS-1:0] ovf_next;
    logic irq_reg;

    // which pairs exist under the current extension configuration
    assign present[3:0] = '1; // [RL1]
    assign present[5:4] = {2{ctrl_reg[CTRL_CORE_EXT]}}; // [RL2]
    assign present[9:6] = {4{ctrl_reg[CTRL_ICN]}}; // [RL3]
    assign present[13:10] = {4{ctrl_reg[CTRL_L2C]}}; // [RL3]

    // -----------------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------------
    logic apbAccess;
    logic apbWrite;
    logic legCtrHit;
    logic legSelHit;
    logic extHit;
    logic ctrlHit;
    logic statusHit;
    logic ovfHit;
    logic [IDX_W-1:0] legIdx;
    logic [IDX_W-1:0] extIdx;
    logic [4:0] extSub;
    logic [IDX_W-1:0] regIdx;
    logic regIsSel;
    logic regIsLo;
    logic regIsHi;
    logic regHit;
    logic mapped;
    logic pairWe;

    assign apbAccess = psel && penable;
    assign apbWrite = apbAccess && pwrite;
    // legacy window: counters as lo/hi word pairs, selectors one word each
    assign legCtrHit = (paddr[11:6] == OFF_LEG_CTR[11:6]) && (paddr[5:0] < 6'h20);
    assign legSelHit = (paddr[11:6] == OFF_LEG_SEL[11:6]) && (paddr[5:0] < 6'h10);
    assign legIdx = legCtrHit ? IDX_W'(paddr[4:3]) : IDX_W'(paddr[3:2]);
    assign extIdx = IDX_W'(paddr[7:EXT_STRIDE_LOG2]);
    assign extSub = paddr[4:0];
    assign extHit = (paddr[11:8] == OFF_EXT[11:8]) && (paddr[7:EXT_STRIDE_LOG2] < 3'd6)
        && (extSub == EXT_SEL || extSub == EXT_CTR_LO || extSub == EXT_CTR_HI);
    assign ctrlHit = paddr == OFF_CTRL;
    assign statusHit = paddr == OFF_STATUS;
    assign ovfHit = paddr == OFF_OVF;
    // both windows resolve to one storage index, so pairs 0-3 alias [RL5]
    assign regIdx = extHit ? extIdx : legIdx;
    assign regIsSel = legSelHit || (extHit && extSub == EXT_SEL);
    assign regIsLo = (legCtrHit && !paddr[2]) || (extHit && extSub == EXT_CTR_LO);
    assign regIsHi = (legCtrHit && paddr[2]) || (extHit && extSub == EXT_CTR_HI);
    assign regHit = (legCtrHit || legSelHit || extHit) && present[regIdx];
    assign mapped = regHit || ctrlHit || statusHit || ovfHit;
    // pair writes land only at the edge that completes the transfer [RL7]
    assign pairWe = apbWrite && pready && regHit;

    // -----------------------------------------------------------------------
    // counter pairs
    // -----------------------------------------------------------------------
    logic [31:0] selArr [MAX_PAIRS];
    logic [CTR_W-1:0] ctrArr [MAX_PAIRS];
    logic [MAX_PAIRS-1:0] wrapArr;

    // duration mode counts each cycle the function is busy [RL11]
    assign evSel = evSync;

    for (genvar i = 0; i < MAX_PAIRS; i++) begin : g_pair
        logic src;
        assign src = selArr[i][SEL_DUR] ? durSync[i] : evSel[i]; // [RL10] [RL11]
        pmc_counter #(.CTR_W(CTR_W)) u_ctr (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .eventIn(src),
            .present(present[i]),
            .selWe(pairWe && regIsSel && regIdx == IDX_W'(i)),
            .selWdata(pwdata),
            .ctrWeLo(pairWe && regIsLo && regIdx == IDX_W'(i)), // [RL7]
            .ctrWeHi(pairWe && regIsHi && regIdx == IDX_W'(i)), // [RL7]
            .ctrWdata(pwdata),
            .selOut(selArr[i]),
            .ctrOut(ctrArr[i]),
            .wrapPulse(wrapArr[i])
        );
    end

    function automatic logic [63:0] wide(input logic [CTR_W-1:0] v);
        wide = {{(64 - CTR_W){1'b0}}, v}; // upper bits read zero [RL6]
    endfunction : wide

    // -----------------------------------------------------------------------
    // apb read data and response
    // -----------------------------------------------------------------------
    logic [31:0] rdMux;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [63:0] rdCtr;

    assign rdCtr = wide(ctrArr[regIdx]);
    assign rdMux = !mapped ? 32'h0000_0000
        : regIsSel && regHit ? selArr[regIdx]
        : regIsLo && regHit ? rdCtr[31:0] // [RL7]
        : regIsHi && regHit ? rdCtr[63:32]
        : ctrlHit ? {28'h0000000, ctrl_reg}
        : statusHit ? {{(32 - MAX_PAIRS){1'b0}}, present}
        : {{(32 - MAX_PAIRS){1'b0}}, ovf_reg};

    // one wait state: answer on the edge after the first access cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= apbAccess && !pready_reg;
            prdata_reg <= (apbAccess && !pready_reg && !pwrite) ? rdMux : 32'h0000_0000;
            pslverr_reg <= apbAccess && !pready_reg && !mapped;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // -----------------------------------------------------------------------
    // control write, sticky overflow, interrupt
    // -----------------------------------------------------------------------
    logic commit;
    assign commit = apbWrite && pready_reg;

    // write-one-to-clear, a new wrap in the same cycle wins
    assign ovf_next = (ovf_reg & ~((commit && ovfHit) ? pwdata[MAX_PAIRS-1:0] : '0))
        | wrapArr; // [RL18]

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RESET;
            ovf_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            if (commit && ctrlHit) begin
                ctrl_reg <= pwdata[3:0];
            end
            ovf_reg <= ovf_next;
            irq_reg <= |ovf_next; // [RL12] [RL17]
        end
    end

    assign overflowIrq = irq_reg;

    // -----------------------------------------------------------------------
    // counter read instruction
    // -----------------------------------------------------------------------
    logic rdValid;
    logic rdAllowed;
    logic [IDX_W-1:0] rdIdx;
    logic [63:0] rdVal;
    logic done_reg;
    logic fault_reg;
    logic [31:0] hi_reg;
    logic [31:0] lo_reg;

    // index space spans core, interconnect and cache groups [RL15]
    assign rdIdx = IDX_W'(readIndex[3:0]);
    assign rdValid = (readIndex < 32'(MAX_PAIRS)) && present[rdIdx];
    assign rdAllowed = !readUser || ctrl_reg[CTRL_UCRE]; // [RL9]
    assign rdVal = wide(ctrArr[rdIdx]);

    // value sampled as it stands, no ordering with other work [RL14]
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            done_reg <= 1'b0;
            fault_reg <= 1'b0;
            hi_reg <= 32'h0000_0000;
            lo_reg <= 32'h0000_0000;
        end else begin
            done_reg <= readReq;
            fault_reg <= readReq && !(rdAllowed && rdValid); // [RL9]
            if (readReq && rdAllowed && rdValid) begin
                hi_reg <= rdVal[63:32]; // [RL8]
                lo_reg <= rdVal[31:0]; // [RL8]
            end
        end
    end

    assign readDone = done_reg;
    assign readFault = fault_reg;
    assign readHigh = hi_reg;
    assign readLow = lo_reg;
endmodule : perf_event_counter_bank

/* rtl/pmc_pkg.sv */
// package: register map, field positions and reset values of the event counter bank
package pmc_pkg;
    // pair groups
    localparam int BASE_PAIRS = 4;
    localparam int CORE_EXT_PAIRS = 2;
    localparam int GROUP_PAIRS = 4;
    localparam int MAX_PAIRS = 14;
    localparam int IDX_W = 4;
    // counter index map, shared by register decode and the read instruction
    localparam logic [3:0] IDX_CORE0 = 4'h0;
    localparam logic [3:0] IDX_ICN0 = 4'h6;
    localparam logic [3:0] IDX_L2C0 = 4'ha;
    // apb byte offsets: legacy window, extended core window, control
    localparam logic [11:0] OFF_LEG_CTR = 12'h000;
    localparam logic [11:0] OFF_LEG_SEL = 12'h040;
    localparam logic [11:0] OFF_EXT = 12'h100;
    localparam logic [11:0] OFF_CTRL = 12'h400;
    localparam logic [11:0] OFF_STATUS = 12'h404;
    localparam logic [11:0] OFF_OVF = 12'h408;
    // extended window: pair n at OFF_EXT + n*0x20; +0 sel, +8 ctr lo, +0xc ctr hi
    localparam int EXT_STRIDE_LOG2 = 5;
    localparam logic [4:0] EXT_SEL = 5'h00;
    localparam logic [4:0] EXT_CTR_LO = 5'h08;
    localparam logic [4:0] EXT_CTR_HI = 5'h0c;
    // selector fields
    localparam int SEL_EN = 22;
    localparam int SEL_INT = 20;
    localparam int SEL_DUR = 0;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEL_MASK = 32'h0050_0001;
    // control fields
    localparam int CTRL_UCRE = 0;
    localparam int CTRL_CORE_EXT = 1;
    localparam int CTRL_ICN = 2;
    localparam int CTRL_L2C = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int CTR_MAX_W = 64;
endpackage : pmc_pkg

/* rtl/pmc_sync2.sv */
// two-flop synchroniser for event inputs
`timescale 1ns/1ps
module pmc_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] out_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta_reg <= '0;
            out_reg <= '0;
        end else begin
            meta_reg <= din;
            out_reg <= meta_reg;
        end
    end

    assign dout = out_reg;
endmodule : pmc_sync2

/* rtl/pmc_counter.sv */
// one counter with its selector: counts events or duration, wraps on overflow
`timescale 1ns/1ps
module pmc_counter
    import pmc_pkg::*;
#(
    parameter int CTR_W = 48
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // event source, already synchronised
    input wire logic eventIn,
    // pair present in this configuration
    input wire logic present,
    // software access
    input wire logic selWe,
    input wire logic [31:0] selWdata,
    input wire logic ctrWeLo,
    input wire logic ctrWeHi,
    input wire logic [31:0] ctrWdata,
    // state
    output logic [31:0] selOut,
    output logic [CTR_W-1:0] ctrOut,
    output logic wrapPulse
);
    logic [31:0] sel_reg;
    logic [CTR_W-1:0] ctr_reg;
    logic [CTR_W-1:0] ctr_next;
    logic [63:0] ctrWide;
    logic wrap_reg;
    logic countEn;
    logic allOnes;

    // only its own selector steers this counter [RL4] [RL16]
    assign countEn = present && sel_reg[SEL_EN] && eventIn; // [RL10] [RL11]
    assign allOnes = &ctr_reg;
    assign ctrWide = {{(64 - CTR_W){1'b0}}, ctr_reg};

    always_comb begin
        ctr_next = ctr_reg;
        if (ctrWeLo) begin
            ctr_next[31:0] = ctrWdata; // [RL7]
        end else if (ctrWeHi) begin
            ctr_next = CTR_W'({ctrWdata, ctrWide[31:0]}); // [RL6] [RL7]
        end else if (countEn) begin
            ctr_next = ctr_reg + 1'b1; // wraps to zero [RL18]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sel_reg <= SEL_RESET;
            ctr_reg <= '0;
            wrap_reg <= 1'b0;
        end else begin
            if (selWe) begin
                sel_reg <= selWdata & SEL_MASK;
            end
            ctr_reg <= ctr_next;
            wrap_reg <= countEn && allOnes && !ctrWeLo && !ctrWeHi && sel_reg[SEL_INT]; // [RL17]
        end
    end

    assign selOut = sel_reg;
    assign ctrOut = ctr_reg;
    assign wrapPulse = wrap_reg;
endmodule : pmc_counter

/* testbench/perf_event_counter_bank_properties.sv */
// checker: apb and counter read port timing of the event counter bank
`timescale 1ns/1ps
module perf_event_counter_bank_checker
    import pmc_pkg::*;
#(
    parameter int CTR_W = 48
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // counter read port
    input wire logic readReq,
    input wire logic [31:0] readIndex,
    input wire logic readDone,
    input wire logic readFault,
    input wire logic [31:0] readHigh,
    input wire logic [31:0] readLow
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // ---------------------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------------------
    chk_ready_after_access: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access cycle");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    // ---------------------------------------------------------------------------
    // counter read port
    // ---------------------------------------------------------------------------
    chk_done_next: assert property (readReq |=> readDone)
        else $error("read done missing after request");
    chk_done_cause: assert property (readDone |-> $past(readReq))
        else $error("read done without request");
    chk_fault_range: assert property (readReq && readIndex >= MAX_PAIRS |=> readFault)
        else $error("index out of range not refused");
    chk_fault_done: assert property (readFault |-> readDone)
        else $error("read fault without done");
    chk_data_hold: assert property (!readDone || readFault |-> $stable({readHigh, readLow}))
        else $error("read data changed without good read");
    chk_high_width: assert property (readHigh >> (CTR_W - 32) == 32'h0)
        else $error("read high word wider than counter");
endmodule : perf_event_counter_bank_checker

bind perf_event_counter_bank perf_event_counter_bank_checker #(.CTR_W(CTR_W)) u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .readReq(readReq), .readIndex(readIndex),
    .readDone(readDone), .readFault(readFault), .readHigh(readHigh), .readLow(readLow)
);

/* testbench/event_source.sv */
// event source model: per-pair event pulses and function-busy levels
`timescale 1ns/1ps
module event_source
    import pmc_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // event lines toward the counter bank
    output logic [MAX_PAIRS-1:0] eventPulse,
    output logic [MAX_PAIRS-1:0] durationActive
);
    initial begin
        eventPulse = '0;
        durationActive = '0;
    end
    // n separate one-cycle occurrences on one pair
    task automatic pulse(input int pair, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            eventPulse[pair] <= 1'b1;
            @(posedge clk_sys);
            eventPulse[pair] <= 1'b0;
        end
    endtask : pulse
    // function busy for n cycles on one pair
    task automatic busy(input int pair, input int n);
        @(posedge clk_sys);
        durationActive[pair] <= 1'b1;
        repeat (n) @(posedge clk_sys);
        durationActive[pair] <= 1'b0;
    endtask : busy
endmodule : event_source

/* testbench/testbench.sv */
// testbench: apb and counter read sequences against the event counter bank
`timescale 1ns/1ps
module testbench;
    import pmc_pkg::*;
    localparam int CW = 48;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, readHigh, readLow;
    logic pready, pslverr, readDone, readFault, overflowIrq;
    logic [MAX_PAIRS-1:0] eventPulse, durationActive;
    logic readReq = 1'b0;
    logic [31:0] readIndex = 32'h0;
    logic readUser = 1'b0;
    int err_total = 0;
    int checks_done = 0;
    always #10 clk_sys = ~clk_sys;
    event_source src (.clk_sys(clk_sys), .eventPulse(eventPulse),
        .durationActive(durationActive));
    perf_event_counter_bank #(.CTR_W(CW)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eventPulse(eventPulse),
        .durationActive(durationActive), .readReq(readReq), .readIndex(readIndex),
        .readUser(readUser), .readDone(readDone), .readFault(readFault),
        .readHigh(readHigh), .readLow(readLow), .overflowIrq(overflowIrq));
    // ---------------------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) err_total++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk_bit(e, err);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk_bit(e, err);
        chk_word(r, exp);
    endtask : rd
    task automatic rdi(input logic [31:0] idx, input logic user, input logic flt,
        input logic [31:0] hi, input logic [31:0] lo);
        @(posedge clk_sys);
        readReq <= 1'b1;
        readIndex <= idx;
        readUser <= user;
        @(posedge clk_sys);
        readReq <= 1'b0;
        @(posedge clk_sys);
        chk_bit(readDone, 1'b1);
        chk_bit(readFault, flt);
        if (!flt) begin
            chk_word(readHigh, hi);
            chk_word(readLow, lo);
        end
    endtask : rdi
    // ---------------------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(OFF_CTRL, 32'h0, 1'b0);
        rd(OFF_STATUS, 32'h0000_000f, 1'b0);
        rd(12'h7f0, 32'h0, 1'b1);
        wr(12'h180, 32'h0040_0000, 1'b1);
        rdi(32'h6, 1'b0, 1'b1, 32'h0, 32'h0);
        wr(OFF_CTRL, 32'h0000_000f, 1'b0);
        rd(OFF_STATUS, 32'h0000_3fff, 1'b0);
        wr(12'h04c, 32'hffff_ffff, 1'b0);
        rd(12'h160, 32'h0050_0001, 1'b0);
        wr(12'h160, 32'h0, 1'b0);
        rd(12'h04c, 32'h0, 1'b0);
        wr(12'h168, 32'h1234_5678, 1'b0);
        wr(12'h16c, 32'hffff_ffff, 1'b0);
        rd(12'h018, 32'h1234_5678, 1'b0);
        rd(12'h01c, 32'h0000_ffff, 1'b0);
        rdi(32'h3, 1'b0, 1'b0, 32'h0000_ffff, 32'h1234_5678);
        // pair 1 enabled only, pair 2 events are not counted
        wr(12'h044, 32'h0040_0000, 1'b0);
        src.pulse(1, 5);
        src.pulse(2, 3);
        repeat (4) @(posedge clk_sys);
        rd(12'h008, 32'h5, 1'b0);
        rd(12'h010, 32'h0, 1'b0);
        wr(12'h044, 32'h0, 1'b0);
        src.pulse(1, 2);
        repeat (4) @(posedge clk_sys);
        rd(12'h008, 32'h5, 1'b0);
        wr(12'h180, 32'h0040_0001, 1'b0);
        src.busy(4, 7);
        repeat (4) @(posedge clk_sys);
        rdi(32'h4, 1'b0, 1'b0, 32'h0, 32'h7);
        rdi(32'ha, 1'b1, 1'b0, 32'h0, 32'h0);
        rdi(32'he, 1'b0, 1'b1, 32'h0, 32'h0);
        wr(OFF_CTRL, 32'h0000_000e, 1'b0);
        rdi(32'h4, 1'b1, 1'b1, 32'h0, 32'h0);
        rdi(32'h4, 1'b0, 1'b0, 32'h0, 32'h7);
        // preload minus three, interrupt enabled
        wr(12'h040, 32'h0050_0000, 1'b0);
        wr(12'h000, 32'hffff_fffd, 1'b0);
        wr(12'h004, 32'hffff_ffff, 1'b0);
        src.pulse(0, 2);
        repeat (4) @(posedge clk_sys);
        chk_bit(overflowIrq, 1'b0);
        src.pulse(0, 1);
        repeat (4) @(posedge clk_sys);
        chk_bit(overflowIrq, 1'b1);
        rd(12'h000, 32'h0, 1'b0);
        rd(12'h004, 32'h0, 1'b0);
        rd(OFF_OVF, 32'h1, 1'b0);
        wr(OFF_OVF, 32'h1, 1'b0);
        repeat (2) @(posedge clk_sys);
        chk_bit(overflowIrq, 1'b0);
        // wrap with interrupt disabled
        wr(12'h040, 32'h0040_0000, 1'b0);
        wr(12'h000, 32'hffff_ffff, 1'b0);
        wr(12'h004, 32'hffff_ffff, 1'b0);
        src.pulse(0, 1);
        repeat (4) @(posedge clk_sys);
        rd(12'h000, 32'h0, 1'b0);
        chk_bit(overflowIrq, 1'b0);
        rd(OFF_OVF, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule : testbench
